// ### src/gfdm_pkg.sv
// Constants, field layouts and types shared by the pin function and misc control logic
package gfdm_pkg;

    // ------------------------------------------------------------------
    // Register map and reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] GFDM_ADDR_MISC   = 8'h07;
    localparam logic [7:0] GFDM_ADDR_PIN1   = 8'h0a;
    localparam logic [7:0] GFDM_ADDR_PIN2   = 8'h0b;
    localparam logic [7:0] GFDM_RST_MISC    = 8'h00;
    localparam logic [7:0] GFDM_RST_PIN1    = 8'h32;
    localparam logic [7:0] GFDM_RST_PIN2    = 8'h00;
    localparam logic [7:0] GFDM_RDATA_NONE  = 8'h00;

    // Writable bits of each register; the rest read as zero
    localparam logic [7:0] GFDM_MISC_WMASK  = 8'hf0;
    localparam logic [7:0] GFDM_PIN_WMASK   = 8'hf7;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int GFDM_MISC_CAPDIS_BIT = 7;
    localparam int GFDM_MISC_DLYEN_BIT  = 6;
    localparam int GFDM_MISC_DLYSEL_BIT = 5;
    localparam int GFDM_MISC_CLKRST_BIT = 4;
    localparam int GFDM_PIN_FUNC_LSB    = 4;
    localparam int GFDM_PIN_FUNC_W      = 4;
    localparam int GFDM_PIN_RSVD_BIT    = 3;
    localparam int GFDM_PIN_DRV_LSB     = 0;
    localparam int GFDM_PIN_DRV_W       = 3;

    // ------------------------------------------------------------------
    // Pin function codes
    // ------------------------------------------------------------------
    localparam logic [3:0] GFDM_FN_OFF      = 4'h0;
    localparam logic [3:0] GFDM_FN_GIN      = 4'h1;
    localparam logic [3:0] GFDM_FN_GOUT     = 4'h2;
    localparam logic [3:0] GFDM_FN_IRQ      = 4'h3;
    localparam logic [3:0] GFDM_FN_MICCLK   = 4'h4;
    localparam logic [3:0] GFDM_FN_PDOUT1   = 4'h5;
    localparam logic [3:0] GFDM_FN_PDOUT2   = 4'h6;
    localparam logic [3:0] GFDM_FN_SDOUT1   = 4'h7;
    localparam logic [3:0] GFDM_FN_SDOUT2   = 4'h8;
    localparam logic [3:0] GFDM_FN_SBCLK    = 4'h9;
    localparam logic [3:0] GFDM_FN_SFSYNC   = 4'ha;
    localparam logic [3:0] GFDM_FN_GENERAL_CLOCK_OUTPUT   = 4'hb;
    localparam logic [3:0] GFDM_FN_MUXDOUT  = 4'hc;
    localparam logic [3:0] GFDM_FN_DAISY    = 4'hd;

    // ------------------------------------------------------------------
    // Drive style codes
    // ------------------------------------------------------------------
    localparam logic [2:0] GFDM_DRV_HIZ     = 3'h0;
    localparam logic [2:0] GFDM_DRV_PUSH    = 3'h1;
    localparam logic [2:0] GFDM_DRV_LO_WKHI = 3'h2;
    localparam logic [2:0] GFDM_DRV_LO_HIZ  = 3'h3;
    localparam logic [2:0] GFDM_DRV_WKLO_HI = 3'h4;
    localparam logic [2:0] GFDM_DRV_HIZ_HI  = 3'h5;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned GFDM_CLK_HZ        = 200_000_000;
    localparam int unsigned GFDM_CYC_PER_MS    = GFDM_CLK_HZ / 1000;
    localparam int unsigned GFDM_DLY_SHORT_MS  = 128;
    localparam int unsigned GFDM_DLY_LONG_MS   = 512;
    localparam int unsigned GFDM_CLK_LOSS_MS   = 2;
    localparam int unsigned GFDM_CAP_DIS_MS    = 1;
    localparam int unsigned GFDM_DLY_SHORT_CYC = GFDM_DLY_SHORT_MS * GFDM_CYC_PER_MS;
    localparam int unsigned GFDM_DLY_LONG_CYC  = GFDM_DLY_LONG_MS * GFDM_CYC_PER_MS;
    localparam int unsigned GFDM_CLK_LOSS_CYC  = GFDM_CLK_LOSS_MS * GFDM_CYC_PER_MS;
    localparam int unsigned GFDM_CAP_DIS_CYC   = GFDM_CAP_DIS_MS * GFDM_CYC_PER_MS;

    // DAC power-up sequence
    typedef enum logic [1:0] {
        GFDM_SEQ_OFF,
        GFDM_SEQ_DISCH,
        GFDM_SEQ_DELAY,
        GFDM_SEQ_ON
    } gfdm_seq_t;

endpackage

// ### src/gfdm_pin_if.sv
// Signals between the pin configuration logic and the pin drive decoder
`timescale 1ns/1ps
interface gfdm_pin_if;
    logic [3:0] func;
    logic [2:0] drv;
    logic       value;
    logic       out;
    logic       oe;
    logic       pu;
    logic       pd;

    modport ctrl  (output func, output drv, output value, input out, input oe, input pu, input pd);
    modport drive (input func, input drv, input value, output out, output oe, output pu, output pd);
endinterface

// ### src/gfdm_pin_drive.sv
// Drive style decoder: turns function, drive code and level into pin controls
`timescale 1ns/1ps
module gfdm_pin_drive
    import gfdm_pkg::*;
(
    gfdm_pin_if.drive pin
);

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    logic serial_fn;
    logic out_fn;

    // Serial audio outputs ignore the drive code and always push-pull
    assign serial_fn = (pin.func >= GFDM_FN_PDOUT1 && pin.func <= GFDM_FN_SFSYNC) ||
                       pin.func == GFDM_FN_MUXDOUT || pin.func == GFDM_FN_DAISY;
    assign out_fn    = pin.func >= GFDM_FN_GOUT && pin.func <= GFDM_FN_DAISY;

    // Combinational so a new code reaches the pin on the next register edge
    always_comb begin
        pin.out = pin.value;
        pin.oe  = 1'b0;
        pin.pu  = 1'b0;
        pin.pd  = 1'b0;
        if (serial_fn) begin
            pin.oe = 1'b1;
        end else if (out_fn) begin
            unique case (pin.drv)
                GFDM_DRV_HIZ:     pin.oe = 1'b0;
                GFDM_DRV_PUSH:    pin.oe = 1'b1;
                GFDM_DRV_LO_WKHI: begin
                    pin.oe = ~pin.value;
                    pin.pu = pin.value;
                end
                GFDM_DRV_LO_HIZ:  pin.oe = ~pin.value;
                GFDM_DRV_WKLO_HI: begin
                    pin.oe = pin.value;
                    pin.pd = ~pin.value;
                end
                GFDM_DRV_HIZ_HI:  pin.oe = pin.value;
                default:          pin.oe = 1'b0;        // Reserved codes float the pin
            endcase
        end
    end

endmodule

// ### src/gfdm_top.sv
// Multi-function pin selection and DAC misc control registers
`timescale 1ns/1ps
module gfdm_top
    import gfdm_pkg::*;
#(
    parameter int unsigned DLY_SHORT_CYC = GFDM_DLY_SHORT_CYC,
    parameter int unsigned DLY_LONG_CYC  = GFDM_DLY_LONG_CYC,
    parameter int unsigned CLK_LOSS_CYC  = GFDM_CLK_LOSS_CYC,
    parameter int unsigned CAP_DIS_CYC   = GFDM_CAP_DIS_CYC
)(
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       ce,
    input  wire logic       reg_wr_en,
    input  wire logic       reg_rd_en,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    input  wire logic       dac_powerup_req,
    input  wire logic       sel_clk_present,
    input  wire logic       irq_level,
    input  wire logic       gout_level,
    input  wire logic       mic_clk,
    input  wire logic       pri_dout1,
    input  wire logic       pri_second_serial_data_out,
    input  wire logic       sec_dout1,
    input  wire logic       sec_second_serial_data_out,
    input  wire logic       sec_bclk,
    input  wire logic       sec_frame_sync,
    input  wire logic       gen_clk,
    input  wire logic       daisy_dout,
    input  wire logic       pin1_in,
    output logic            pin1_out,
    output logic            pin1_oe,
    output logic            pin1_pu_en,
    output logic            pin1_pd_en,
    output logic            gin_level,
    output logic            cap_discharge_active,
    output logic            dac_power_on,
    output logic            hard_reset_req
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  misc;
        logic [7:0]  pin1;
        logic [7:0]  pin2;
        logic [7:0]  rdata;
        gfdm_seq_t   seq;
        logic [31:0] timer;
        logic [31:0] loss_cnt;
        logic        hard_rst;
        logic        p_out;
        logic        p_oe;
        logic        p_pu;
        logic        p_pd;
        logic        gin;
        logic        cap_act;
        logic        dac_on;
    } gfdm_state_t;

    gfdm_state_t st_reg;
    gfdm_state_t st_next;
    gfdm_pin_if  pin1_bus ();
    logic        src_level;
    logic [31:0] dly_limit;

    // ------------------------------------------------------------------
    // Pin source selection
    // ------------------------------------------------------------------
    // Muxed data is an OR: each serial port idles low outside its own slots
    always_comb begin
        unique case (st_reg.pin1[GFDM_PIN_FUNC_LSB +: GFDM_PIN_FUNC_W])
            GFDM_FN_GOUT:    src_level = gout_level;
            GFDM_FN_IRQ:     src_level = irq_level;
            GFDM_FN_MICCLK:  src_level = mic_clk;
            GFDM_FN_PDOUT1:  src_level = pri_dout1;
            GFDM_FN_PDOUT2:  src_level = pri_second_serial_data_out;
            GFDM_FN_SDOUT1:  src_level = sec_dout1;
            GFDM_FN_SDOUT2:  src_level = sec_second_serial_data_out;
            GFDM_FN_SBCLK:   src_level = sec_bclk;
            GFDM_FN_SFSYNC:  src_level = sec_frame_sync;
            GFDM_FN_GENERAL_CLOCK_OUTPUT:  src_level = gen_clk;
            GFDM_FN_MUXDOUT: src_level = pri_dout1 | sec_dout1;
            GFDM_FN_DAISY:   src_level = daisy_dout;
            default:         src_level = 1'b0;                    // Off, input, reserved
        endcase
    end

    // Decoder reads the live register, so a write acts at the next edge
    assign pin1_bus.func  = st_reg.pin1[GFDM_PIN_FUNC_LSB +: GFDM_PIN_FUNC_W];
    assign pin1_bus.drv   = st_reg.pin1[GFDM_PIN_DRV_LSB +: GFDM_PIN_DRV_W];
    assign pin1_bus.value = src_level;

    gfdm_pin_drive u_pin1_drive (
        .pin (pin1_bus.drive)
    );

    // Selected power-up delay
    assign dly_limit = st_reg.misc[GFDM_MISC_DLYSEL_BIT] ? 32'(DLY_LONG_CYC)
                                                         : 32'(DLY_SHORT_CYC);

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        st_next = st_reg;

        // Register writes; reserved bits are masked so they always read zero
        if (reg_wr_en) begin
            unique case (reg_addr)
                GFDM_ADDR_MISC: st_next.misc = reg_wdata & GFDM_MISC_WMASK;
                GFDM_ADDR_PIN1: st_next.pin1 = reg_wdata & GFDM_PIN_WMASK;
                GFDM_ADDR_PIN2: st_next.pin2 = reg_wdata & GFDM_PIN_WMASK;
                default: ;
            endcase
        end

        // Registered read data; unmapped addresses read zero
        if (reg_rd_en) begin
            unique case (reg_addr)
                GFDM_ADDR_MISC: st_next.rdata = st_reg.misc;
                GFDM_ADDR_PIN1: st_next.rdata = st_reg.pin1;
                GFDM_ADDR_PIN2: st_next.rdata = st_reg.pin2;
                default:        st_next.rdata = GFDM_RDATA_NONE;
            endcase
        end

        // Pin controls and sampled input
        st_next.p_out = pin1_bus.out;
        st_next.p_oe  = pin1_bus.oe;
        st_next.p_pu  = pin1_bus.pu;
        st_next.p_pd  = pin1_bus.pd;
        if (pin1_bus.func == GFDM_FN_GIN) begin
            st_next.gin = pin1_in;
        end

        // DAC power-up: optional discharge, optional delay, then on
        st_next.timer = st_reg.timer + 32'h1;
        unique case (st_reg.seq)
            GFDM_SEQ_OFF: begin
                st_next.timer = 32'h0;
                if (dac_powerup_req) begin
                    if (st_reg.misc[GFDM_MISC_CAPDIS_BIT]) begin
                        st_next.seq = GFDM_SEQ_DISCH;
                    end else if (st_reg.misc[GFDM_MISC_DLYEN_BIT]) begin
                        st_next.seq = GFDM_SEQ_DELAY;
                    end else begin
                        st_next.seq = GFDM_SEQ_ON;
                    end
                end
            end
            GFDM_SEQ_DISCH: begin
                if (st_reg.timer >= 32'(CAP_DIS_CYC - 1)) begin
                    st_next.timer = 32'h0;
                    st_next.seq   = st_reg.misc[GFDM_MISC_DLYEN_BIT] ? GFDM_SEQ_DELAY
                                                                     : GFDM_SEQ_ON;
                end
            end
            GFDM_SEQ_DELAY: begin
                if (st_reg.timer >= dly_limit - 32'h1) begin
                    st_next.timer = 32'h0;
                    st_next.seq   = GFDM_SEQ_ON;
                end
            end
            GFDM_SEQ_ON: begin
                st_next.timer = 32'h0;
            end
        endcase
        if (!dac_powerup_req) begin
            st_next.seq   = GFDM_SEQ_OFF;
            st_next.timer = 32'h0;
        end
        // Phase flags get their own flops so the outputs carry no decode
        st_next.cap_act = st_next.seq == GFDM_SEQ_DISCH;
        st_next.dac_on  = st_next.seq == GFDM_SEQ_ON;

        // Clock loss watchdog; counter saturates at the limit
        if (!st_reg.misc[GFDM_MISC_CLKRST_BIT] || sel_clk_present) begin
            st_next.loss_cnt = 32'h0;
        end else if (st_reg.loss_cnt < 32'(CLK_LOSS_CYC)) begin
            st_next.loss_cnt = st_reg.loss_cnt + 32'h1;
        end
        st_next.hard_rst = st_next.loss_cnt >= 32'(CLK_LOSS_CYC);
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    // Clock enable low freezes every bit of state
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg          <= '0;
            st_reg.misc     <= GFDM_RST_MISC;
            st_reg.pin1     <= GFDM_RST_PIN1;
            st_reg.pin2     <= GFDM_RST_PIN2;
            st_reg.seq      <= GFDM_SEQ_OFF;
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from flip-flops
    assign reg_rdata            = st_reg.rdata;
    assign pin1_out             = st_reg.p_out;
    assign pin1_oe              = st_reg.p_oe;
    assign pin1_pu_en           = st_reg.p_pu;
    assign pin1_pd_en           = st_reg.p_pd;
    assign gin_level            = st_reg.gin;
    assign cap_discharge_active = st_reg.cap_act;
    assign dac_power_on         = st_reg.dac_on;
    assign hard_reset_req       = st_reg.hard_rst;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    disch_enter_a: assert property (@(posedge clk) disable iff (!arst_n)
        ce && dac_powerup_req && st_reg.seq == GFDM_SEQ_OFF && st_reg.misc[GFDM_MISC_CAPDIS_BIT]
        |=> cap_discharge_active)
        else $error("discharge phase not entered");

    disch_skip_a: assert property (@(posedge clk) disable iff (!arst_n)
        ce && st_reg.seq == GFDM_SEQ_OFF && !st_reg.misc[GFDM_MISC_CAPDIS_BIT]
        |=> !cap_discharge_active)
        else $error("discharge phase entered while disabled");

    delay_skip_a: assert property (@(posedge clk) disable iff (!arst_n)
        ce && dac_powerup_req && st_reg.seq == GFDM_SEQ_OFF &&
        !st_reg.misc[GFDM_MISC_CAPDIS_BIT] && !st_reg.misc[GFDM_MISC_DLYEN_BIT]
        |=> dac_power_on)
        else $error("undelayed power-up did not turn on at once");

    delay_bound_a: assert property (@(posedge clk) disable iff (!arst_n)
        st_reg.seq == GFDM_SEQ_DELAY |-> st_reg.timer < dly_limit)
        else $error("power-up delay overran selected interval");

    clock_loss_a: assert property (@(posedge clk) disable iff (!arst_n)
        hard_reset_req |-> st_reg.loss_cnt == 32'(CLK_LOSS_CYC) &&
                           ($past(st_reg.misc[GFDM_MISC_CLKRST_BIT]) || !$past(ce)))
        else $error("hard reset without full clock loss");

    misc_rsvd_read_a: assert property (@(posedge clk) disable iff (!arst_n)
        ce && reg_rd_en && reg_addr == GFDM_ADDR_MISC |=> reg_rdata[3:0] == 4'h0)
        else $error("misc reserved bits read nonzero");

    pin_rsvd_bit_a: assert property (@(posedge clk) disable iff (!arst_n)
        ce && reg_wr_en && reg_addr == GFDM_ADDR_PIN1 |=> !st_reg.pin1[GFDM_PIN_RSVD_BIT])
        else $error("pin reserved bit stored");

    serial_push_a: assert property (@(posedge clk) disable iff (!arst_n)
        ce && pin1_bus.func == GFDM_FN_PDOUT1 |=> pin1_oe && pin1_out == $past(pri_dout1))
        else $error("serial output not push-pull");

    write_apply_a: assert property (@(posedge clk) disable iff (!arst_n)
        ce && reg_wr_en && reg_addr == GFDM_ADDR_PIN1
        |=> pin1_bus.func == $past(reg_wdata[GFDM_PIN_FUNC_LSB +: GFDM_PIN_FUNC_W]) &&
            pin1_bus.drv == $past(reg_wdata[GFDM_PIN_DRV_LSB +: GFDM_PIN_DRV_W]))
        else $error("pin code write not applied");

endmodule

// ### bench/test_gfdm_top.sv
// Self-checking bench for the pin function and DAC misc control block
`timescale 1ns/1ps
module test_gfdm_top
    import gfdm_pkg::*;
();

    // ------------------------------------------------------------------
    // Shortened counts keep the run brief
    // ------------------------------------------------------------------
    localparam int unsigned T_SHORT = 20;
    localparam int unsigned T_LONG  = 80;
    localparam int unsigned T_LOSS  = 16;
    localparam int unsigned T_CAP   = 8;

    logic        clk     = 1'b0;
    logic        arst_n  = 1'b0;
    logic        ce      = 1'b1;
    logic        wr_en   = 1'b0;
    logic        rd_en   = 1'b0;
    logic [7:0]  addr    = 8'h00;
    logic [7:0]  wdata   = 8'h00;
    logic [7:0]  rdata;
    logic        pwr_req = 1'b0;
    logic        clk_ok  = 1'b1;
    logic [10:0] src     = 11'h000;
    logic        pin_in  = 1'b0;
    logic        pin_out;
    logic        pin_oe;
    logic        pin_pu;
    logic        pin_pd;
    logic        gin;
    logic        cap_act;
    logic        dac_on;
    logic        hrst;
    int          error_cnt  = 0;
    int          n_compared = 0;

    // Clock: 5 ns period
    always #2.5 clk = ~clk;

    gfdm_top #(.DLY_SHORT_CYC(T_SHORT), .DLY_LONG_CYC(T_LONG),
               .CLK_LOSS_CYC(T_LOSS), .CAP_DIS_CYC(T_CAP)) gfdm_top_inst (
        .clk(clk), .arst_n(arst_n), .ce(ce), .reg_wr_en(wr_en), .reg_rd_en(rd_en),
        .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata),
        .dac_powerup_req(pwr_req), .sel_clk_present(clk_ok),
        .irq_level(src[0]), .gout_level(src[1]), .mic_clk(src[2]),
        .pri_dout1(src[3]), .pri_second_serial_data_out(src[4]), .sec_dout1(src[5]),
        .sec_second_serial_data_out(src[6]), .sec_bclk(src[7]), .sec_frame_sync(src[8]),
        .gen_clk(src[9]), .daisy_dout(src[10]), .pin1_in(pin_in),
        .pin1_out(pin_out), .pin1_oe(pin_oe), .pin1_pu_en(pin_pu),
        .pin1_pd_en(pin_pd), .gin_level(gin), .cap_discharge_active(cap_act),
        .dac_power_on(dac_on), .hard_reset_req(hrst));

    // ------------------------------------------------------------------
    // Shared helpers
    // ------------------------------------------------------------------
    task automatic conclude();
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask

    // Inputs always move 1 ns after the rising edge
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Leading step keeps two back-to-back calls from retoggling the strobe at once
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        step(1);
        addr = a;
        wdata = d;
        wr_en = 1'b1;
        step(1);
        wr_en = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        step(1);
        addr = a;
        rd_en = 1'b1;
        step(1);
        rd_en = 1'b0;
        d = rdata;
    endtask

    // Source index carried by each function code
    function automatic int idx(input logic [3:0] c);
        case (c)
            4'h2: return 1;
            4'h3: return 0;
            4'h4: return 2;
            4'h5, 4'hc: return 3;
            4'h6: return 4;
            4'h7: return 5;
            4'h8: return 6;
            4'h9: return 7;
            4'ha: return 8;
            4'hb: return 9;
            4'hd: return 10;
            default: return 0;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_regs();
        logic [7:0] d;
        // Pin flops only follow the reset function after the first edge past release
        step(1);
        chk("pin oe irq low", pin_oe, 1'b1);
        src[0] = 1'b1;
        step(2);
        chk("pin oe irq high", pin_oe, 1'b0);
        chk("pin pu irq high", pin_pu, 1'b1);
        rd(8'h07, d);
        chk("misc reset", d, 8'h00);
        rd(8'h0a, d);
        chk("pin one reset", d, 8'h32);
        rd(8'h0b, d);
        chk("pin two reset", d, 8'h00);
        // Clock enable low must swallow the write
        ce = 1'b0;
        addr = 8'h0a;
        wdata = 8'h21;
        wr_en = 1'b1;
        step(1);
        wr_en = 1'b0;
        ce = 1'b1;
        rd(8'h0a, d);
        chk("pin one frozen", d, 8'h32);
        // Host keeps reserved bits at zero and drive codes legal
        wr(8'h07, 8'hf0);
        rd(8'h07, d);
        chk("misc fields", d, 8'hf0);
        wr(8'h07, 8'h00);
        wr(8'h0a, 8'hf5);
        rd(8'h0a, d);
        chk("pin one fields", d, 8'hf5);
        wr(8'h0b, 8'hf5);
        rd(8'h0b, d);
        chk("pin two fields", d, 8'hf5);
        wr(8'h08, 8'h5a);
        rd(8'h08, d);
        chk("unmapped", d, 8'h00);
        rd(8'h07, d);
        chk("misc untouched", d, 8'h00);
    endtask

    // One-hot sources with push-pull, then complement with hi-z drive code
    task automatic t_func();
        logic ser;
        logic drv;
        logic lv;
        for (int c = 0; c < 16; c++) begin
            for (int ph = 0; ph < 2; ph++) begin
                src = 11'h001 << idx(4'(c));
                if (ph == 1) src = ~src;
                wr(8'h0a, {4'(c), 4'(1 - ph)});
                step(1);
                ser = (c >= 5 && c <= 10) || c == 12 || c == 13;
                drv = (c >= 2 && c <= 13) && (ph == 0 || ser);
                chk("func oe", pin_oe, drv);
                lv = (c == 12) ? (src[3] | src[5]) : src[idx(4'(c))];
                if (drv) chk("func out", pin_out, lv);
            end
        end
    endtask

    // General output under each legal drive style and both levels
    task automatic t_drive();
        logic lv;
        logic drv;
        for (int d = 0; d < 6; d++) begin
            for (int l = 0; l < 2; l++) begin
                lv = 1'(l);
                src = {9'h000, lv, 1'b0};
                wr(8'h0a, {4'h2, 1'b0, 3'(d)});
                step(1);
                drv = d == 1 || (lv ? (d == 4 || d == 5) : (d == 2 || d == 3));
                chk("drive oe", pin_oe, drv);
                chk("drive pu", pin_pu, d == 2 && lv);
                chk("drive pd", pin_pd, d == 4 && !lv);
                if (drv) chk("drive out", pin_out, lv);
            end
        end
    endtask

    task automatic t_gin();
        wr(8'h0a, 8'h12);
        pin_in = 1'b1;
        step(2);
        chk("gin high", gin, 1'b1);
        pin_in = 1'b0;
        step(2);
        chk("gin low", gin, 1'b0);
        wr(8'h0a, 8'h22);
        pin_in = 1'b1;
        step(2);
        chk("gin held", gin, 1'b0);
    endtask

    // Power-up latency and discharge length for every misc timing mode
    task automatic t_dac();
        logic [7:0] m [6] = '{8'h00, 8'h80, 8'h40, 8'h60, 8'hc0, 8'he0};
        int n;
        int dis;
        int exp;
        for (int i = 0; i < 6; i++) begin
            wr(8'h07, m[i]);
            pwr_req = 1'b1;
            n = 0;
            dis = 0;
            while (n < 300 && dac_on !== 1'b1) begin
                step(1);
                n++;
                if (cap_act === 1'b1) dis++;
            end
            exp = 1 + (m[i][7] ? T_CAP : 0) + (m[i][6] ? (m[i][5] ? T_LONG : T_SHORT) : 0);
            chk("power-up latency", 8'(n), 8'(exp));
            chk("discharge cycles", 8'(dis), m[i][7] ? 8'(T_CAP) : 8'h00);
            step(3);
            chk("dac stays on", dac_on, 1'b1);
            pwr_req = 1'b0;
            step(2);
            chk("dac off", dac_on, 1'b0);
        end
        // Request dropped in mid-discharge aborts the sequence
        wr(8'h07, 8'hc0);
        pwr_req = 1'b1;
        step(4);
        chk("discharge running", cap_act, 1'b1);
        pwr_req = 1'b0;
        step(2);
        chk("discharge aborted", cap_act, 1'b0);
        chk("dac not on", dac_on, 1'b0);
    endtask

    task automatic t_loss();
        wr(8'h07, 8'h10);
        clk_ok = 1'b0;
        step(T_LOSS - 1);
        chk("reset early", hrst, 1'b0);
        step(1);
        chk("reset raised", hrst, 1'b1);
        clk_ok = 1'b1;
        step(2);
        chk("reset cleared", hrst, 1'b0);
        wr(8'h07, 8'h00);
        clk_ok = 1'b0;
        step(T_LOSS + 4);
        chk("reset disabled", hrst, 1'b0);
        clk_ok = 1'b1;
    endtask

    // ------------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        step(5);
        arst_n = 1'b1;
        t_regs();
        t_func();
        t_drive();
        t_gin();
        t_dac();
        t_loss();
        conclude();
    end

    // Whole run is about five hundred cycles; this span is far beyond it
    initial begin
        #200000;
        error_cnt++;
        $display("unexpected watchdog: expected done, seen hang");
        conclude();
    end
endmodule
